// ===== common/mcss_pkg.sv
/*
 types shared by the core: command word, standby modes, mode registers, pins.
 assumes the decoder outside presents one command per instruction cycle.
*/
package mcss_pkg;
	// micro operations presented by the instruction decoder
	typedef enum logic [4:0] {OP_NOP, OP_LOAD_RAM, OP_STORE_RAM, OP_ADD_CARRY,
		OP_ADD_SKIP, OP_A_TO_X, OP_X_TO_A, OP_LOAD_PTR, OP_SWAP_PTR,
		OP_TABLE_FETCH, OP_PORT_OUT, OP_PORT_IN, OP_JUMP, OP_CALL, OP_RETURN,
		OP_IRQ_ENTRY, OP_IRQ_ON, OP_IRQ_OFF, OP_HALT, OP_STOP} mcss_op_e;
	// standby modes
	typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_STOP} mcss_mode_e;
	// one command
	typedef struct packed {
		logic        valid;
		mcss_op_e    op;
		logic [7:0]  imm;
		logic [11:0] target;
	} mcss_cmd_s;
	// mode registers
	typedef struct packed {
		logic [3:0] analogPinCtrl;
		logic [7:0] convDataCtrl;
		logic [7:0] convData;
		logic [7:0] timerCount;
		logic [7:0] timerReload;
		logic [3:0] timerCtrl;
		logic [3:0] irqMask;
		logic [3:0] portTwoDir;
	} mcss_cfg_s;
	// pin drive
	typedef struct packed {
		logic [3:0] highCurrentN;
		logic [3:0] p2Out;
		logic [3:0] p2Oe;
		logic [3:0] p4Out;
		logic [3:0] p4Oe;
		logic [3:0] p5Out;
		logic [3:0] p5Oe;
	} mcss_pins_s;
endpackage : mcss_pkg

// ===== common/mcss_regs.svh
/*
 holds selector codes, reserved pages, reset values and counts of the core.
 assumes inclusion by bare name from the core files.
*/
`ifndef MCSS_REGS_SVH
`define MCSS_REGS_SVH
// port and mode register selectors (ram column pointer)
`define MCSS_SEL_HC_LATCH 4'h0
`define MCSS_SEL_WAKE_IN 4'h1
`define MCSS_SEL_IO_TWO 4'h2
`define MCSS_SEL_ANALOG_IN 4'h3
`define MCSS_SEL_IO_FOUR 4'h4
`define MCSS_SEL_IO_FIVE 4'h5
`define MCSS_SEL_CONV_CTRL 4'h8
`define MCSS_SEL_CONV_DATA 4'h9
`define MCSS_SEL_TMR_COUNT 4'hA
`define MCSS_SEL_TMR_RELOAD 4'hB
`define MCSS_SEL_TMR_CTRL 4'hC
`define MCSS_SEL_IRQ_MASK 4'hE
`define MCSS_SEL_DIR_TWO 4'hF
// read-only compare bit position in converter control
`define MCSS_CMP_BIT_POS 4
// reserved program pages and interrupt vector steps
`define MCSS_PAGE_RESET 6'h00
`define MCSS_PAGE_IRQ 6'h02
`define MCSS_PAGE_TABLE 6'h04
`define MCSS_VEC_A 6'h00
`define MCSS_VEC_B 6'h02
`define MCSS_VEC_T 6'h04
// stack and reset values
`define MCSS_STACK_DEPTH 4
`define MCSS_LEVEL_RESET 3'h1
`define MCSS_LATCH_RESET 4'h0
// reset sequence counts
`define MCSS_RST_ENTRY_CYC 2
`define MCSS_RST_OSC_PULSES 32768
`endif

// ===== core/mcss_adder.sv
/*
 four-bit binary adder with carry in and carry out.
 assumes operands settle within one clock.
*/
module mcss_adder (
	input  wire logic [3:0] augend,
	input  wire logic [3:0] addend,
	input  wire logic       carryIn,
	output logic      [3:0] sum,
	output logic            carryOut
);
	// full five-bit result
	logic [4:0] total;
	assign total    = {1'b0, augend} + {1'b0, addend} + {4'h0, carryIn};
	assign sum      = total[3:0];
	assign carryOut = total[4];
endmodule : mcss_adder

// ===== core/mcss_core.sv
/*
 core state of a small four-bit controller: accumulators, adder, ram pointer,
 data ram, program counter with return stack, program memory, port and mode
 registers, reset condition and standby modes.
 assumes an outside decoder issues commands and loads program memory.
*/
`include "mcss_regs.svh"
module mcss_core #(
	parameter int unsigned RST_OSC_PULSES = `MCSS_RST_OSC_PULSES
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               clkEn,
	input  wire logic               resetPinN,
	input  wire logic               oscPulse,
	input  mcss_pkg::mcss_cmd_s     cmd,
	input  wire logic [3:0]         p1Pins,
	input  wire logic [3:0]         p2Pins,
	input  wire logic [3:0]         p3Pins,
	input  wire logic [3:0]         p4Pins,
	input  wire logic [3:0]         p5Pins,
	input  wire logic               compareResult,
	input  wire logic               timerOvf,
	input  wire logic               romWrEn,
	input  wire logic [10:0]        romWrAddr,
	input  wire logic [7:0]         romWrData,
	output mcss_pkg::mcss_pins_s    pins,
	output mcss_pkg::mcss_cfg_s     cfg,
	output logic      [11:0]        pc,
	output logic      [7:0]         instrByte,
	output logic                    skipActive,
	output logic                    irqReq,
	output logic                    inReset,
	output logic                    sysClkRun,
	output logic                    mainClkRun,
	output logic      [3:0]         accum,
	output logic      [3:0]         auxAccum,
	output logic                    carryFlag
);
	import mcss_pkg::*;

	// storage arrays
	logic [3:0]  ram_r [128];                    // data ram words
	logic [7:0]  rom_r [2048];                   // program memory
	logic [11:0] stack_r [`MCSS_STACK_DEPTH];    // return stack
	// core registers
	logic [3:0]  acc_r;        // working accumulator
	logic [3:0]  aux_r;        // auxiliary accumulator
	logic        carry_r;      // carry flag
	logic [7:0]  ptr_r;        // ram row and column pointer
	logic [7:0]  save_r;       // pointer save register
	logic [5:0]  page_r;       // page field
	logic [5:0]  step_r;       // step counter
	logic [2:0]  level_r;      // stack level, 1 is empty
	logic        skipNext_r;   // next command discarded
	logic [2:0]  pend_r;       // timer, b, a pending
	logic        gate_r;       // global interrupt gate
	logic [1:0]  p1Prev_r;     // previous wake inputs a, b
	logic [3:0]  p0Latch_r;    // high-current latch
	logic [3:0]  p2Latch_r;    // port two latch
	logic [3:0]  p4Latch_r;    // port four latch
	logic [3:0]  p5Latch_r;    // port five latch
	logic        p4Drive_r;    // port four driven
	logic        p5Drive_r;    // port five driven
	logic [7:0]  instr_r;      // fetched program byte
	mcss_cfg_s   cfg_r;        // mode registers
	mcss_mode_e  mode_r;       // standby mode
	// next values
	logic [3:0]  acc_nxt;
	logic [3:0]  aux_nxt;
	logic        carry_nxt;
	logic [7:0]  ptr_nxt;
	logic [11:0] pc_nxt;
	logic [2:0]  level_nxt;
	logic [2:0]  pend_nxt;
	mcss_mode_e  mode_nxt;
	// decode wires
	mcss_op_e    op;           // current operation
	logic        exec;         // command takes effect
	logic        skipEat;      // command discarded by skip
	logic        running;      // not in reset or standby
	logic [3:0]  sel;          // port selector
	logic [3:0]  ramWord;      // addressed ram word
	logic [7:0]  tableByte;    // table fetch byte
	logic [11:0] seqPc;        // sequential address
	logic [3:0]  addend;       // second adder operand
	logic        addCin;       // adder carry in
	logic [3:0]  sum;          // adder result
	logic        carryOut;     // adder carry out
	logic [7:0]  portRd;       // selected read data
	logic [2:0]  irqClr;       // flag taken at entry
	logic [5:0]  irqVec;       // entry step
	logic [2:0]  irqSet;       // new events
	logic        wake;         // standby release
	logic        pushOk;       // stack has room
	logic [1:0]  pushIdx;      // slot being written
	logic [1:0]  popIdx;       // slot being read

	// eight-bit mode registers use the pair
	function automatic logic selWide(input logic [3:0] s);
		selWide = (s == `MCSS_SEL_CONV_CTRL) || (s == `MCSS_SEL_CONV_DATA) ||
			(s == `MCSS_SEL_TMR_COUNT) || (s == `MCSS_SEL_TMR_RELOAD);
	endfunction : selWide

	// reset pin sequencer
	mcss_reset_seq #(
		.OSC_PULSES (RST_OSC_PULSES)
	) u_seq (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clkEn     (clkEn),
		.resetPinN (resetPinN),
		.oscPulse  (oscPulse),
		.inReset   (inReset)
	);

	// arithmetic unit
	mcss_adder u_add (
		.augend   (acc_r),
		.addend   (addend),
		.carryIn  (addCin),
		.sum      (sum),
		.carryOut (carryOut)
	);

	// command gating
	assign op      = cmd.op;
	assign running = !inReset && (mode_r == MODE_RUN);
	assign exec    = clkEn && cmd.valid && running && !skipNext_r;
	assign skipEat = clkEn && cmd.valid && running && skipNext_r;
	assign sel     = ptr_r[3:0];
	assign ramWord = ram_r[ptr_r[6:0]];
	assign tableByte = rom_r[{5'(`MCSS_PAGE_TABLE), aux_r[1:0], acc_r}];
	assign seqPc   = {page_r, 6'(step_r + 6'h01)};

	// adder operands
	assign addend = (op == OP_ADD_SKIP) ? cmd.imm[3:0] : ramWord;
	assign addCin = (op == OP_ADD_CARRY) ? carry_r : 1'b0;

	// accumulator paths
	assign acc_nxt = (op == OP_LOAD_RAM) ? ramWord :
		(op == OP_ADD_CARRY || op == OP_ADD_SKIP) ? sum :
		(op == OP_X_TO_A) ? aux_r :
		(op == OP_TABLE_FETCH) ? tableByte[3:0] :
		(op == OP_PORT_IN) ? portRd[3:0] : acc_r;
	assign aux_nxt = (op == OP_A_TO_X) ? acc_r :
		(op == OP_TABLE_FETCH) ? tableByte[7:4] :
		(op == OP_PORT_IN && selWide(sel)) ? portRd[7:4] : aux_r;
	assign carry_nxt = (op == OP_ADD_CARRY) ? carryOut : carry_r;
	assign ptr_nxt = (op == OP_LOAD_PTR) ? cmd.imm :
		(op == OP_SWAP_PTR) ? save_r : ptr_r;

	// stack indexing
	assign pushOk  = level_r <= 3'(`MCSS_STACK_DEPTH);
	assign pushIdx = 2'(level_r - 3'h1);
	assign popIdx  = 2'(level_r - 3'h2);
	assign level_nxt = ((op == OP_CALL || op == OP_IRQ_ENTRY) && pushOk) ? 3'(level_r + 3'h1) :
		(op == OP_RETURN && level_r > `MCSS_LEVEL_RESET) ? 3'(level_r - 3'h1) : level_r;

	// interrupt vector, a before b before timer
	assign irqClr = pend_r[0] ? 3'h1 : pend_r[1] ? 3'h2 : pend_r[2] ? 3'h4 : 3'h0;
	assign irqVec = pend_r[0] ? `MCSS_VEC_A : pend_r[1] ? `MCSS_VEC_B : `MCSS_VEC_T;
	assign irqSet = {timerOvf, p1Prev_r[1] & ~p1Pins[1], p1Prev_r[0] & ~p1Pins[0]};
	// set wins over clear at entry
	assign pend_nxt = (pend_r & ~((exec && op == OP_IRQ_ENTRY) ? irqClr : 3'h0)) | irqSet;

	// next program counter
	assign pc_nxt = (op == OP_JUMP || op == OP_CALL) ? cmd.target :
		(op == OP_RETURN) ? stack_r[popIdx] :
		(op == OP_IRQ_ENTRY) ? {`MCSS_PAGE_IRQ, irqVec} : seqPc;

	// standby release sources
	assign wake = !resetPinN || !p1Pins[2] || !p1Pins[3] ||
		(!p1Pins[0] && cfg_r.irqMask[0]) || (!p1Pins[1] && cfg_r.irqMask[1]) ||
		(timerOvf && cfg_r.irqMask[2]);
	assign mode_nxt = (exec && op == OP_HALT) ? MODE_HALT :
		(exec && op == OP_STOP) ? MODE_STOP :
		(mode_r != MODE_RUN && wake) ? MODE_RUN : mode_r;

	// port and mode register read selection
	always_comb
	begin
		portRd = 8'h00;
		case (sel)
			`MCSS_SEL_WAKE_IN: portRd = {4'h0, p1Pins};
			`MCSS_SEL_IO_TWO: portRd = {4'h0, (p2Latch_r & cfg_r.portTwoDir) | (p2Pins & ~cfg_r.portTwoDir)};
			`MCSS_SEL_ANALOG_IN: portRd = {4'h0, p3Pins};
			`MCSS_SEL_IO_FOUR: portRd = {4'h0, p4Drive_r ? p4Latch_r : p4Pins};
			`MCSS_SEL_IO_FIVE: portRd = {4'h0, p5Drive_r ? p5Latch_r : p5Pins};
			`MCSS_SEL_CONV_CTRL: portRd = {cfg_r.convDataCtrl[7:5], compareResult, cfg_r.convDataCtrl[3:0]};
			`MCSS_SEL_CONV_DATA: portRd = cfg_r.convData;
			`MCSS_SEL_TMR_COUNT: portRd = cfg_r.timerCount;
			`MCSS_SEL_TMR_RELOAD: portRd = cfg_r.timerReload;
			`MCSS_SEL_TMR_CTRL: portRd = {4'h0, cfg_r.timerCtrl};
			`MCSS_SEL_IRQ_MASK: portRd = {4'h0, cfg_r.irqMask};
			`MCSS_SEL_DIR_TWO: portRd = {4'h0, cfg_r.portTwoDir};
			default:      portRd = 8'h00; // write-only or absent
		endcase
	end

	// datapath registers, not cleared by the reset condition
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			acc_r   <= 4'h0;
			aux_r   <= 4'h0;
			carry_r <= 1'b0;
			ptr_r   <= 8'h00;
			save_r  <= 8'h00;
		end
		else if (exec)
		begin
			acc_r   <= acc_nxt;
			aux_r   <= aux_nxt;
			carry_r <= carry_nxt;
			ptr_r   <= ptr_nxt;
			save_r  <= (op == OP_SWAP_PTR) ? ptr_r : save_r;
		end
	end

	// sequencing registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{page_r, step_r} <= 12'h000;
			level_r    <= `MCSS_LEVEL_RESET;
			skipNext_r <= 1'b0;
			mode_r     <= MODE_RUN;
		end
		else if (clkEn && inReset)
		begin
			{page_r, step_r} <= 12'h000;
			level_r    <= `MCSS_LEVEL_RESET;
			skipNext_r <= 1'b0;
			mode_r     <= MODE_RUN;
		end
		else if (clkEn)
		begin
			{page_r, step_r} <= exec ? pc_nxt : skipEat ? seqPc : {page_r, step_r};
			level_r    <= exec ? level_nxt : level_r;
			skipNext_r <= (exec && op == OP_ADD_SKIP) ? carryOut : skipEat ? 1'b0 : skipNext_r;
			mode_r     <= mode_nxt;
		end
	end

	// interrupt flags and wake edge history
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pend_r   <= 3'h0;
			gate_r   <= 1'b0;
			p1Prev_r <= 2'h3;
		end
		else if (clkEn)
		begin
			pend_r   <= inReset ? 3'h0 : pend_nxt;
			gate_r   <= inReset ? 1'b0 : (exec && op == OP_IRQ_ON) ? 1'b1 :
				(exec && op == OP_IRQ_OFF) ? 1'b0 : gate_r;
			p1Prev_r <= p1Pins[1:0];
		end
	end

	// output latches and mode registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{p0Latch_r, p2Latch_r, p4Latch_r, p5Latch_r} <= {4{`MCSS_LATCH_RESET}};
			{p4Drive_r, p5Drive_r} <= 2'h0;
			cfg_r <= '0;
		end
		else if (clkEn && inReset)
		begin
			{p0Latch_r, p2Latch_r, p4Latch_r, p5Latch_r} <= {4{`MCSS_LATCH_RESET}};
			{p4Drive_r, p5Drive_r} <= 2'h0;
			cfg_r <= '0;
		end
		else if (exec && op == OP_PORT_OUT)
		begin
			case (sel)
				`MCSS_SEL_HC_LATCH: p0Latch_r <= acc_r;
				`MCSS_SEL_IO_TWO: p2Latch_r <= acc_r;
				`MCSS_SEL_ANALOG_IN: cfg_r.analogPinCtrl <= acc_r;
				`MCSS_SEL_IO_FOUR: {p4Latch_r, p4Drive_r} <= {acc_r, 1'b1};
				`MCSS_SEL_IO_FIVE: {p5Latch_r, p5Drive_r} <= {acc_r, 1'b1};
				`MCSS_SEL_CONV_CTRL: cfg_r.convDataCtrl <= {aux_r[3:1], 1'b0, acc_r};
				`MCSS_SEL_CONV_DATA: cfg_r.convData <= {aux_r, acc_r};
				`MCSS_SEL_TMR_COUNT: cfg_r.timerCount <= {aux_r, acc_r};
				`MCSS_SEL_TMR_RELOAD: cfg_r.timerReload <= {aux_r, acc_r};
				`MCSS_SEL_TMR_CTRL: cfg_r.timerCtrl <= acc_r;
				`MCSS_SEL_IRQ_MASK: cfg_r.irqMask <= acc_r;
				`MCSS_SEL_DIR_TWO: cfg_r.portTwoDir <= acc_r;
				default: ; // input-only or absent selectors
			endcase
		end
	end

	// arrays: ram, stack, program memory and fetch
	always_ff @(posedge ref_clk)
	begin
		if (exec && op == OP_STORE_RAM)
			ram_r[ptr_r[6:0]] <= acc_r;
		if (exec && pushOk && (op == OP_CALL || op == OP_IRQ_ENTRY || op == OP_TABLE_FETCH))
			stack_r[pushIdx] <= (op == OP_CALL) ? seqPc : {page_r, step_r};
		if (clkEn && romWrEn)
			rom_r[romWrAddr] <= romWrData;
		if (clkEn)
			instr_r <= rom_r[{page_r[4:0], step_r}];
	end

	// outputs
	assign pins.highCurrentN = ~p0Latch_r;
	assign pins.p2Out = p2Latch_r;
	assign pins.p2Oe  = cfg_r.portTwoDir;
	assign pins.p4Out = p4Latch_r;
	assign pins.p4Oe  = {4{p4Drive_r}};
	assign pins.p5Out = p5Latch_r;
	assign pins.p5Oe  = {4{p5Drive_r}};
	assign cfg        = cfg_r;
	assign pc         = {page_r, step_r};
	assign instrByte  = instr_r;
	assign skipActive = skipNext_r;
	assign irqReq     = gate_r && |(pend_r & cfg_r.irqMask[2:0]);
	assign sysClkRun  = mode_r == MODE_RUN;
	assign mainClkRun = mode_r != MODE_STOP;
	assign accum      = acc_r;
	assign auxAccum   = aux_r;
	assign carryFlag  = carry_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_add_carry;
		exec && op == OP_ADD_CARRY |=>
			{carry_r, acc_r} == 5'({1'b0, $past(acc_r)} + {1'b0, $past(ramWord)} + {4'h0, $past(carry_r)});
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry add result wrong");
	property p_add_skip;
		exec && op == OP_ADD_SKIP |=> $stable(carry_r) && skipNext_r == $past(carryOut);
	endproperty
	a_add_skip: assert property (p_add_skip) else $error("constant add changed carry or skip");
	property p_swap;
		exec && op == OP_SWAP_PTR |=> ptr_r == $past(save_r) && save_r == $past(ptr_r);
	endproperty
	a_swap: assert property (p_swap) else $error("pointer swap failed");
	property p_step;
		exec && (op == OP_NOP || op == OP_LOAD_RAM) && !inReset |=>
			step_r == 6'($past(step_r) + 6'h01) && page_r == $past(page_r);
	endproperty
	a_step: assert property (p_step) else $error("step counter did not advance");
	property p_irq_push;
		exec && op == OP_IRQ_ENTRY && pushOk |=>
			page_r == `MCSS_PAGE_IRQ && level_r == 3'($past(level_r) + 3'h1);
	endproperty
	a_irq_push: assert property (p_irq_push) else $error("interrupt entry did not push");
	property p_reset_pc;
		inReset && clkEn |-> !exec ##1 (pc == 12'h000 && level_r == `MCSS_LEVEL_RESET);
	endproperty
	a_reset_pc: assert property (p_reset_pc) else $error("reset did not hold pc at zero");
	property p_reset_pins;
		inReset && clkEn |=> pins.highCurrentN == 4'hF && pins.p2Oe == 4'h0 && pins.p4Oe == 4'h0;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("reset left pins driven");
	property p_compare_bit;
		exec && op == OP_PORT_IN && sel == `MCSS_SEL_CONV_CTRL |=> aux_r[0] == $past(compareResult);
	endproperty
	a_compare_bit: assert property (p_compare_bit) else $error("compare bit read wrong");
	property p_halt;
		exec && op == OP_HALT && !wake |=> !sysClkRun && mainClkRun;
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not gate system clock");
	property p_release;
		clkEn && mode_r != MODE_RUN && wake |=> mode_r == MODE_RUN;
	endproperty
	a_release: assert property (p_release) else $error("standby not released");

	c_table: cover property (exec && op == OP_TABLE_FETCH);
	c_skip: cover property (exec && op == OP_ADD_SKIP ##1 skipNext_r);
	c_stop_wake: cover property (mode_r == MODE_STOP ##1 mode_r == MODE_RUN);
endmodule : mcss_core

// ===== core/mcss_reset_seq.sv
/*
 reset pin sequencer: entry delay while pin is low, pulse count on release.
 assumes reset pin and oscillator pulse are synchronous to ref_clk.
*/
`include "mcss_regs.svh"
module mcss_reset_seq #(
	parameter int unsigned OSC_PULSES = `MCSS_RST_OSC_PULSES
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic resetPinN,
	input  wire logic oscPulse,
	output logic      inReset
);
	typedef enum logic [1:0] {SEQ_RUN, SEQ_ENTRY, SEQ_HELD, SEQ_COUNT} mcss_seq_e;
	mcss_seq_e   state_r;   // sequencer state
	mcss_seq_e   state_nxt; // next state
	logic [15:0] cnt_r;     // entry or pulse count
	logic [15:0] cnt_nxt;   // next count
	logic        pulseDone; // last pulse seen
	assign pulseDone = oscPulse && (cnt_r == 16'(OSC_PULSES - 1));
	// next state
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			SEQ_RUN:
			begin
				// first low cycle counts as one
				if (!resetPinN)
				begin
					state_nxt = SEQ_ENTRY;
					cnt_nxt   = 16'h0001;
				end
			end
			SEQ_ENTRY:
			begin
				if (resetPinN)
					state_nxt = SEQ_RUN; // glitch shorter than entry
				else if (cnt_r == 16'(`MCSS_RST_ENTRY_CYC - 1))
					state_nxt = SEQ_HELD;
				else
					cnt_nxt = cnt_r + 16'h0001;
			end
			SEQ_HELD:
			begin
				if (resetPinN)
				begin
					state_nxt = SEQ_COUNT;
					cnt_nxt   = 16'h0000;
				end
			end
			SEQ_COUNT:
			begin
				if (!resetPinN)
					state_nxt = SEQ_HELD; // pin low again restarts
				else if (pulseDone)
					state_nxt = SEQ_RUN;
				else if (oscPulse)
					cnt_nxt = cnt_r + 16'h0001;
			end
			default: state_nxt = SEQ_HELD;
		endcase
	end
	// state registers, power-on starts held
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= SEQ_HELD;
			cnt_r   <= 16'h0000;
		end
		else if (clkEn)
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end
	assign inReset = (state_r == SEQ_HELD) || (state_r == SEQ_COUNT);
	// two low cycles from run reach reset
	property p_entry_delay;
		@(posedge ref_clk) disable iff (rst)
		(state_r == SEQ_RUN && !resetPinN && clkEn) ##1 (!resetPinN && clkEn) |=> inReset;
	endproperty
	a_entry_delay: assert property (p_entry_delay) else $error("reset entry not after two cycles");
	// no early release while counting
	property p_hold_count;
		@(posedge ref_clk) disable iff (rst)
		(state_r == SEQ_COUNT && !pulseDone) |=> inReset;
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("reset released before pulse count");
endmodule : mcss_reset_seq

// ===== test/tb_mcu_core_state_reset_standby.sv
/*
 self-checking bench for mcss_core: command table, latches, standby, reset pin.
 assumes mcss_pkg and mcss_core are compiled first; ref_clk runs at 40 MHz.
*/
module tb_mcu_core_state_reset_standby;
	timeunit 1ns;
	timeprecision 1ps;
	import mcss_pkg::*;
	// one command with its expected {acc,aux,carry,pc}
	typedef struct {
		mcss_op_e    op;
		logic [7:0]  imm;
		logic [11:0] tgt;
		logic [23:0] exp;
	} mcss_row_s;
	localparam int unsigned PULSES = 8; // shortened release count
	logic        ref_clk, rst, clkEn, resetPinN, oscPulse;
	logic        compareResult, timerOvf, romWrEn;
	logic [3:0]  p1Pins, p2Pins, p3Pins, p4Pins, p5Pins;
	logic [10:0] romWrAddr;
	logic [7:0]  romWrData;
	mcss_cmd_s   cmd;
	mcss_pins_s  pins;
	mcss_cfg_s   cfg;
	logic [11:0] pc;
	logic [7:0]  instrByte;
	logic        skipActive, irqReq, inReset, sysClkRun, mainClkRun, carryFlag;
	logic [3:0]  accum, auxAccum;
	int          err_count, comparisons;
	// ordinary cases, one command each
	mcss_row_s rows [21] = '{
		'{OP_ADD_SKIP, 8'h09, 12'h0, 24'h900001}, '{OP_STORE_RAM, 8'h0, 12'h0, 24'h900002},
		'{OP_ADD_CARRY, 8'h0, 12'h0, 24'h201003}, '{OP_ADD_CARRY, 8'h0, 12'h0, 24'hC00004},
		'{OP_LOAD_PTR, 8'h17, 12'h0, 24'hC00005}, '{OP_SWAP_PTR, 8'h0, 12'h0, 24'hC00006},
		'{OP_A_TO_X, 8'h0, 12'h0, 24'hCC0007}, '{OP_LOAD_RAM, 8'h0, 12'h0, 24'h9C0008},
		'{OP_ADD_SKIP, 8'h08, 12'h0, 24'h1C0009}, '{OP_ADD_SKIP, 8'h0F, 12'h0, 24'h1C000A},
		'{OP_X_TO_A, 8'h0, 12'h0, 24'hCC000B}, '{OP_JUMP, 8'h0, 12'h0C0, 24'hCC00C0},
		'{OP_CALL, 8'h0, 12'h100, 24'hCC0100}, '{OP_RETURN, 8'h0, 12'h0, 24'hCC00C1},
		'{OP_LOAD_PTR, 8'h00, 12'h0, 24'hCC00C2}, '{OP_PORT_OUT, 8'h0, 12'h0, 24'hCC00C3},
		'{OP_LOAD_PTR, 8'h08, 12'h0, 24'hCC00C4}, '{OP_PORT_OUT, 8'h0, 12'h0, 24'hCC00C5},
		'{OP_PORT_IN, 8'h0, 12'h0, 24'hCD00C6}, '{OP_TABLE_FETCH, 8'h0, 12'h0, 24'hA500C7},
		'{OP_HALT, 8'h0, 12'h0, 24'hA500C8}};
	mcss_core #(.RST_OSC_PULSES(PULSES)) mcss_core_i (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
		.resetPinN(resetPinN), .oscPulse(oscPulse), .cmd(cmd), .p1Pins(p1Pins), .p2Pins(p2Pins),
		.p3Pins(p3Pins), .p4Pins(p4Pins), .p5Pins(p5Pins), .compareResult(compareResult),
		.timerOvf(timerOvf), .romWrEn(romWrEn), .romWrAddr(romWrAddr), .romWrData(romWrData),
		.pins(pins), .cfg(cfg), .pc(pc), .instrByte(instrByte), .skipActive(skipActive), .irqReq(irqReq),
		.inReset(inReset), .sysClkRun(sysClkRun), .mainClkRun(mainClkRun), .accum(accum),
		.auxAccum(auxAccum), .carryFlag(carryFlag));
	// free-running clock
	always #12.5 ref_clk = ~ref_clk;
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// verdict and stop
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	// one command, taken at the next rising edge
	task automatic issue(input mcss_op_e op, input logic [7:0] imm, input logic [11:0] tgt);
		@(negedge ref_clk);
		cmd = '{1'b1, op, imm, tgt};
		@(negedge ref_clk);
		cmd.valid = 1'b0;
	endtask : issue
	// release count with pin high, exact pulse number
	task automatic release_seq();
		resetPinN = 1'b1;
		for (int i = 0; i < PULSES; i++)
		begin
			@(negedge ref_clk);
			oscPulse = 1'b1;
			@(negedge ref_clk);
			oscPulse = 1'b0;
			chk(inReset, (i == PULSES - 1) ? 0 : 1);
		end
	endtask : release_seq
	// hang guard
	initial
	begin
		#(25 * 3000);
		err_count++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		ref_clk = 0; rst = 1; clkEn = 1; resetPinN = 1; oscPulse = 0; cmd = '0;
		p1Pins = 4'hF; p2Pins = 4'h5; p3Pins = 4'hA; p4Pins = 4'h3; p5Pins = 4'h6;
		compareResult = 1; timerOvf = 0; romWrEn = 0; romWrAddr = '0; romWrData = '0;
		repeat (12) @(negedge ref_clk);
		chk({pc, pins.highCurrentN, pins.p2Oe, inReset}, {12'h000, 4'hF, 4'h0, 1'b1});
		chk(32'(cfg[47:32]), 32'h0);
		chk(cfg[31:0], 32'h0);
		rst = 0;
		release_seq();
		// table byte at page four, {aux[1:0],acc} = 1C
		@(negedge ref_clk);
		romWrEn = 1; romWrAddr = 11'h11C; romWrData = 8'h5A;
		@(negedge ref_clk);
		romWrEn = 0;
		foreach (rows[i])
		begin
			issue(rows[i].op, rows[i].imm, rows[i].tgt);
			chk({accum, auxAccum, 3'b000, carryFlag, pc}, rows[i].exp);
		end
		chk(pins.highCurrentN, 4'h3);
		chk(cfg.convDataCtrl, 8'hCC);
		chk({sysClkRun, mainClkRun}, 2'b01);
		issue(OP_ADD_SKIP, 8'h01, 12'h0);
		chk({accum, pc}, {4'hA, 12'h0C8});
		@(negedge ref_clk);
		p1Pins = 4'hB;
		@(negedge ref_clk);
		p1Pins = 4'hF;
		chk(sysClkRun, 1);
		issue(OP_STOP, 8'h0, 12'h0);
		chk({sysClkRun, mainClkRun, pc}, {2'b00, 12'h0C9});
		@(negedge ref_clk);
		p1Pins = 4'h7;
		@(negedge ref_clk);
		p1Pins = 4'hF;
		chk(mainClkRun, 1);
		// reset pin: held for two cycles before entry
		@(negedge ref_clk);
		resetPinN = 0;
		@(negedge ref_clk);
		chk(inReset, 0);
		@(negedge ref_clk);
		chk(inReset, 1);
		// reset condition clears state on the following edge
		@(negedge ref_clk);
		chk({pc, pins.highCurrentN, pins.p2Oe}, {12'h000, 4'hF, 4'h0});
		issue(OP_JUMP, 8'h0, 12'h3C0);
		chk(pc, 12'h000);
		release_seq();
		chk(pc, 12'h000);
		// clock enable low freezes the program counter
		clkEn = 0;
		issue(OP_JUMP, 8'h0, 12'h11C);
		chk(pc, 12'h000);
		clkEn = 1;
		// fetch of the table byte written earlier
		issue(OP_JUMP, 8'h0, 12'h11C);
		@(negedge ref_clk);
		chk(instrByte, 8'h5A);
		// mask from acc (A), gate on, falling edge on wake input b
		issue(OP_LOAD_PTR, 8'h0E, 12'h0);
		issue(OP_PORT_OUT, 8'h0, 12'h0);
		issue(OP_IRQ_ON, 8'h0, 12'h0);
		@(negedge ref_clk);
		p1Pins = 4'hD;
		@(negedge ref_clk);
		p1Pins = 4'hF;
		chk({cfg.irqMask, irqReq}, {4'hA, 1'b1});
		issue(OP_IRQ_ENTRY, 8'h0, 12'h0);
		chk({irqReq, pc}, {1'b0, 12'h082});
		end_of_test();
	end
endmodule : tb_mcu_core_state_reset_standby
